//--- hdl/rcmc_pkg.sv
package rcmc_pkg;

    // Clock and timing
    localparam longint CLK_HZ       = 40_000_000;
    localparam longint WINDOW_S     = 30;
    localparam longint RUN_MAX_S    = 10;
    localparam longint PAUSE_MS     = 500;
    localparam longint WINDOW_CYC   = WINDOW_S * CLK_HZ;
    localparam longint RUN_MAX_CYC  = RUN_MAX_S * CLK_HZ;
    localparam longint PAUSE_CYC    = (PAUSE_MS * CLK_HZ + 999) / 1000;

    // Speed threshold for the automatic raise
    localparam logic [7:0]  SPEED_RAISE_KMH = 8'h14;

    localparam int          CNT_W    = 32;
    localparam logic [31:0] CNT_ZERO = 32'h0;
    localparam logic [31:0] CNT_ONE  = 32'h1;

    // Direction of travel
    localparam logic DIR_UP   = 1'b1;
    localparam logic DIR_DOWN = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_UP    = 2'b01,
        ST_DOWN  = 2'b10,
        ST_PAUSE = 2'b11
    } rcmc_state_type;

    // Pin inputs, all from outside the clock domain
    typedef struct packed {
        logic curtain_switch;
        logic ignition_switched_feed;
        logic inhibitor_reverse;
        logic inhibitor_park;
        logic motor_overcurrent;
    } rcmc_pin_type;

    // Motor drive outputs
    typedef struct packed {
        logic up;
        logic down;
    } rcmc_motor_type;

    localparam rcmc_pin_type   PIN_RST   = '{default: 1'b0};
    localparam rcmc_motor_type MOTOR_OFF = '{default: 1'b0};

endpackage

//--- hdl/rcmc_controller.sv
`timescale 1ns/100ps

// Operation
// - Each press outside the pause reverses the previous travel direction; a press during the pause is ignored
// - First press after battery connect goes up
// - Press during travel: stop, pause, then reverse
// - Overcurrent ends travel, both outputs off
// - Presses accepted 30 s after ignition off
// - Travel in progress finishes past window expiry
// - Motor stopped after 10 s of running
// - Reverse gear lowers raised curtain with ignition on
// - After reverse lowering, raise above 20 km/h
// - After reverse lowering, park raises the curtain
// - Manual lowering disables reverse and speed features
module rcmc_controller #(
    parameter logic [31:0] WINDOW_CYC  = 32'(rcmc_pkg::WINDOW_CYC),
    parameter logic [31:0] RUN_MAX_CYC = 32'(rcmc_pkg::RUN_MAX_CYC),
    parameter logic [31:0] PAUSE_CYC   = 32'(rcmc_pkg::PAUSE_CYC)
) (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire rcmc_pkg::rcmc_pin_type   pins,
    input  wire logic [7:0]               speed_kmh,
    output rcmc_pkg::rcmc_motor_type      motor_cmd_ff
);

    function automatic logic cnt_done(input logic [31:0] cnt, input logic [31:0] lim);
        cnt_done = (cnt >= (lim - rcmc_pkg::CNT_ONE));
    endfunction

    // Input synchroniser and edge detection
    rcmc_pkg::rcmc_pin_type  sync1_ff;
    rcmc_pkg::rcmc_pin_type  sync2_ff;
    rcmc_pkg::rcmc_pin_type  prev_ff;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_ff <= rcmc_pkg::PIN_RST;
            sync2_ff <= rcmc_pkg::PIN_RST;
            prev_ff  <= rcmc_pkg::PIN_RST;
        end else begin
            sync1_ff <= pins;
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    logic ignition_state;
    logic press;
    logic rev_rise;
    logic park_rise;
    logic ovc;
    assign ignition_state       = sync2_ff.ignition_switched_feed;
    assign press     = sync2_ff.curtain_switch & ~prev_ff.curtain_switch;
    assign rev_rise  = sync2_ff.inhibitor_reverse & ~prev_ff.inhibitor_reverse;
    assign park_rise = sync2_ff.inhibitor_park & ~prev_ff.inhibitor_park;
    assign ovc       = sync2_ff.motor_overcurrent;

    // Post-ignition-off operating window
    logic [31:0] win_cnt_ff;
    logic [31:0] nxt_win_cnt;
    logic        win_active_ff;
    logic        nxt_win_active;
    logic        accept;

    always_comb begin
        nxt_win_cnt    = win_cnt_ff;
        nxt_win_active = win_active_ff;
        if (ignition_state) begin
            nxt_win_cnt    = rcmc_pkg::CNT_ZERO;
            nxt_win_active = 1'b1;
        end else if (win_active_ff) begin
            if (cnt_done(win_cnt_ff, WINDOW_CYC)) begin
                nxt_win_active = 1'b0;
            end else begin
                nxt_win_cnt = win_cnt_ff + rcmc_pkg::CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            win_cnt_ff    <= rcmc_pkg::CNT_ZERO;
            win_active_ff <= 1'b0;
        end else begin
            win_cnt_ff    <= nxt_win_cnt;
            win_active_ff <= nxt_win_active;
        end
    end

    assign accept = ignition_state | win_active_ff;

    // Motion control
    rcmc_pkg::rcmc_state_type  state_ff;
    rcmc_pkg::rcmc_state_type  nxt_state;
    logic [31:0]               cnt_ff;
    logic [31:0]               nxt_cnt;
    logic                      last_dir_ff;
    logic                      nxt_last_dir;
    logic                      pos_up_ff;
    logic                      nxt_pos_up;
    logic                      auto_en_ff;
    logic                      nxt_auto_en;
    logic                      rev_lowered_ff;
    logic                      nxt_rev_lowered;
    rcmc_pkg::rcmc_motor_type  nxt_motor;
    logic                      press_ok;
    logic                      moving;
    logic                      run_done;
    logic                      rev_trig;
    logic                      raise_trig;

    assign press_ok   = press & accept;
    assign moving     = (state_ff == rcmc_pkg::ST_UP) | (state_ff == rcmc_pkg::ST_DOWN);
    assign run_done   = cnt_done(cnt_ff, RUN_MAX_CYC);
    assign rev_trig   = ignition_state & rev_rise & pos_up_ff & auto_en_ff;
    assign raise_trig = rev_lowered_ff &
                        ((ignition_state & auto_en_ff & (speed_kmh > rcmc_pkg::SPEED_RAISE_KMH)) |
                         park_rise);

    always_comb begin
        nxt_state       = state_ff;
        nxt_cnt         = cnt_ff;
        nxt_last_dir    = last_dir_ff;
        nxt_pos_up      = pos_up_ff;
        nxt_auto_en     = auto_en_ff;
        nxt_rev_lowered = rev_lowered_ff;
        case (state_ff)
            rcmc_pkg::ST_IDLE: begin
                nxt_cnt = rcmc_pkg::CNT_ZERO;
                if (press_ok) begin
                    nxt_last_dir    = ~last_dir_ff;
                    nxt_rev_lowered = 1'b0;
                    if (last_dir_ff == rcmc_pkg::DIR_DOWN) begin
                        nxt_state   = rcmc_pkg::ST_UP;
                        nxt_auto_en = 1'b1;
                    end else begin
                        nxt_state  = rcmc_pkg::ST_DOWN;
                        nxt_pos_up = 1'b0;
                        if (pos_up_ff) begin
                            nxt_auto_en = 1'b0;
                        end
                    end
                end else if (rev_trig) begin
                    nxt_state       = rcmc_pkg::ST_DOWN;
                    nxt_last_dir    = rcmc_pkg::DIR_DOWN;
                    nxt_pos_up      = 1'b0;
                    nxt_rev_lowered = 1'b1;
                end else if (raise_trig) begin
                    nxt_state       = rcmc_pkg::ST_UP;
                    nxt_last_dir    = rcmc_pkg::DIR_UP;
                    nxt_rev_lowered = 1'b0;
                end
            end
            rcmc_pkg::ST_UP, rcmc_pkg::ST_DOWN: begin
                if (ovc | run_done) begin
                    nxt_state = rcmc_pkg::ST_IDLE;
                    if (state_ff == rcmc_pkg::ST_UP) begin
                        nxt_pos_up = 1'b1;
                    end
                end else if (press_ok) begin
                    nxt_state       = rcmc_pkg::ST_PAUSE;
                    nxt_cnt         = rcmc_pkg::CNT_ZERO;
                    nxt_rev_lowered = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff + rcmc_pkg::CNT_ONE;
                end
            end
            rcmc_pkg::ST_PAUSE: begin
                if (cnt_done(cnt_ff, PAUSE_CYC)) begin
                    nxt_cnt      = rcmc_pkg::CNT_ZERO;
                    nxt_last_dir = ~last_dir_ff;
                    if (last_dir_ff == rcmc_pkg::DIR_DOWN) begin
                        nxt_state   = rcmc_pkg::ST_UP;
                        nxt_auto_en = 1'b1;
                    end else begin
                        nxt_state  = rcmc_pkg::ST_DOWN;
                        nxt_pos_up = 1'b0;
                    end
                end else begin
                    nxt_cnt = cnt_ff + rcmc_pkg::CNT_ONE;
                end
            end
            default: begin
                nxt_state = rcmc_pkg::ST_IDLE;
            end
        endcase
        // Outputs follow the next state; every reversal during travel passes the pause state
        nxt_motor.up   = (nxt_state == rcmc_pkg::ST_UP);
        nxt_motor.down = (nxt_state == rcmc_pkg::ST_DOWN);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff       <= rcmc_pkg::ST_IDLE;
            cnt_ff         <= rcmc_pkg::CNT_ZERO;
            last_dir_ff    <= rcmc_pkg::DIR_DOWN;
            pos_up_ff      <= 1'b0;
            auto_en_ff     <= 1'b1;
            rev_lowered_ff <= 1'b0;
            motor_cmd_ff   <= rcmc_pkg::MOTOR_OFF;
        end else begin
            state_ff       <= nxt_state;
            cnt_ff         <= nxt_cnt;
            last_dir_ff    <= nxt_last_dir;
            pos_up_ff      <= nxt_pos_up;
            auto_en_ff     <= nxt_auto_en;
            rev_lowered_ff <= nxt_rev_lowered;
            motor_cmd_ff   <= nxt_motor;
        end
    end

    // Checking helper: any accepted press seen since reset
    logic seen_press_ff;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seen_press_ff <= 1'b0;
        end else if (press_ok) begin
            seen_press_ff <= 1'b1;
        end
    end

    property p_toggle;
        @(posedge clk) disable iff (!rst_b)
        (state_ff == rcmc_pkg::ST_IDLE && press_ok) |=> (last_dir_ff != $past(last_dir_ff));
    endproperty
    a_toggle: assert property (p_toggle) else $error("Press did not toggle direction");
    property p_first_up;
        @(posedge clk) disable iff (!rst_b)
        (state_ff == rcmc_pkg::ST_IDLE && press_ok && !seen_press_ff)
            |=> (state_ff == rcmc_pkg::ST_UP) ##1 motor_cmd_ff.up;
    endproperty
    a_first_up: assert property (p_first_up) else $error("First press did not go up");
    property p_pause_reverse;
        @(posedge clk) disable iff (!rst_b)
        (moving && press_ok && !ovc && !run_done)
            |=> (state_ff == rcmc_pkg::ST_PAUSE) && !motor_cmd_ff.up && !motor_cmd_ff.down;
    endproperty
    a_pause_reverse: assert property (p_pause_reverse) else $error("No pause on press");
    property p_overcurrent;
        @(posedge clk) disable iff (!rst_b)
        (moving && ovc) |=> (state_ff == rcmc_pkg::ST_IDLE) && (motor_cmd_ff == '0);
    endproperty
    a_overcurrent: assert property (p_overcurrent) else $error("Overcurrent did not stop");
    property p_window_closed;
        @(posedge clk) disable iff (!rst_b)
        (state_ff == rcmc_pkg::ST_IDLE && press && !accept) |=> (state_ff == rcmc_pkg::ST_IDLE);
    endproperty
    a_window_closed: assert property (p_window_closed) else $error("Press taken outside window");
    property p_finish_motion;
        @(posedge clk) disable iff (!rst_b)
        (moving && !accept && !ovc && !run_done) |=> (state_ff == $past(state_ff));
    endproperty
    a_finish_motion: assert property (p_finish_motion) else $error("Motion cut at window end");
    property p_run_limit;
        @(posedge clk) disable iff (!rst_b)
        (moving && run_done) |=> !motor_cmd_ff.up && !motor_cmd_ff.down;
    endproperty
    a_run_limit: assert property (p_run_limit) else $error("Run limit not enforced");
    property p_reverse_lower;
        @(posedge clk) disable iff (!rst_b)
        (state_ff == rcmc_pkg::ST_IDLE && !press_ok && rev_trig) |=> motor_cmd_ff.down;
    endproperty
    a_reverse_lower: assert property (p_reverse_lower) else $error("Reverse did not lower");
    property p_no_slow_raise;
        @(posedge clk) disable iff (!rst_b)
        (state_ff == rcmc_pkg::ST_IDLE && !press_ok && !park_rise
            && speed_kmh <= rcmc_pkg::SPEED_RAISE_KMH) |=> !motor_cmd_ff.up;
    endproperty
    a_no_slow_raise: assert property (p_no_slow_raise) else $error("Raise at low speed");
    property p_park_raise;
        @(posedge clk) disable iff (!rst_b)
        (state_ff == rcmc_pkg::ST_IDLE && !press_ok && !rev_trig && rev_lowered_ff && park_rise)
            |=> motor_cmd_ff.up;
    endproperty
    a_park_raise: assert property (p_park_raise) else $error("Park did not raise");
    property p_manual_lock;
        @(posedge clk) disable iff (!rst_b)
        (state_ff == rcmc_pkg::ST_IDLE && !auto_en_ff && !press_ok) |=> !motor_cmd_ff.down;
    endproperty
    a_manual_lock: assert property (p_manual_lock) else $error("Auto lower while disabled");
    property p_exclusive;
        @(posedge clk) disable iff (!rst_b)
        !(motor_cmd_ff.up && motor_cmd_ff.down)
            and ($fell(motor_cmd_ff.up) |-> !motor_cmd_ff.down)
            and ($fell(motor_cmd_ff.down) |-> !motor_cmd_ff.up);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("Motor outputs overlap");

    c_pause: cover property (@(posedge clk) disable iff (!rst_b)
        state_ff == rcmc_pkg::ST_PAUSE ##1 state_ff != rcmc_pkg::ST_PAUSE);
    c_rev: cover property (@(posedge clk) disable iff (!rst_b)
        rev_lowered_ff && motor_cmd_ff.down);
    c_ovc: cover property (@(posedge clk) disable iff (!rst_b) moving && ovc);
    c_window: cover property (@(posedge clk) disable iff (!rst_b) $fell(win_active_ff));

endmodule

//--- test/rcmc_motor_model.sv
`timescale 1ns/100ps

// Curtain drive motor with end stops: stall current while pushed against a stop
module rcmc_motor_model #(
    parameter int TRAVEL = 60
) (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire rcmc_pkg::rcmc_motor_type motor_cmd,
    input  wire logic                     no_end_stop,
    output logic                          overcurrent
);
    int pos_ff;

    // Position in cycles of travel, 0 is fully down
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pos_ff <= 0;
        end else if (motor_cmd.up && pos_ff < TRAVEL) begin
            pos_ff <= pos_ff + 1;
        end else if (motor_cmd.down && pos_ff > 0) begin
            pos_ff <= pos_ff - 1;
        end
    end

    // Removing the stops lets the motor run on with no current rise
    assign overcurrent = !no_end_stop &&
        ((motor_cmd.up && pos_ff == TRAVEL) || (motor_cmd.down && pos_ff == 0));
endmodule

//--- test/tb_top.sv
`timescale 1ns/100ps

module tb_top;
    localparam int         RUN   = 100;
    localparam int         PAU   = 10;
    localparam logic [1:0] M_OFF = 2'h0;
    localparam logic [1:0] M_DN  = 2'h1;
    localparam logic [1:0] M_UP  = 2'h2;

    logic                     clk     = 1'b0;
    logic                     rst_b   = 1'b0;
    logic                     sw      = 1'b0;
    logic                     ignition_state     = 1'b0;
    logic                     rev     = 1'b0;
    logic                     park    = 1'b0;
    logic                     no_stop = 1'b0;
    logic [7:0]               speed   = 8'h00;
    logic                     ovc;
    rcmc_pkg::rcmc_pin_type   pins;
    rcmc_pkg::rcmc_motor_type motor;
    logic [1:0]               m;
    int                       err_count       = 0;
    int                       samples_checked = 0;
    int                       n;

    always #12.5 clk = ~clk;
    assign pins = '{curtain_switch: sw, ignition_switched_feed: ignition_state, inhibitor_reverse: rev,
                    inhibitor_park: park, motor_overcurrent: ovc};
    assign m = motor;

    rcmc_controller #(.WINDOW_CYC(32'hc8), .RUN_MAX_CYC(32'h64), .PAUSE_CYC(32'ha))
        rcmc_controller_inst (.clk(clk), .rst_b(rst_b), .pins(pins), .speed_kmh(speed),
                              .motor_cmd_ff(motor));

    rcmc_motor_model #(.TRAVEL(60)) rcmc_motor_model_inst (.clk(clk), .rst_b(rst_b),
        .motor_cmd(motor), .no_end_stop(no_stop), .overcurrent(ovc));

    always @(posedge clk) begin
        if (m === 2'h3) begin
            err_count++;
            $display("FAIL motor outputs expected not both seen %h", m);
        end
    end

    task automatic give_verdict();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [1:0] exp);
        samples_checked++;
        if (m !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, m);
        end
    endtask

    task automatic check_n(input string what, input int lo, input int hi);
        samples_checked++;
        if (n < lo || n > hi) begin
            err_count++;
            $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, n);
        end
    endtask

    task automatic wait_for(input logic [1:0] exp, input int bound);
        n = 0;
        while (m !== exp) begin
            if (n >= bound) begin
                err_count++;
                $display("FAIL wait for motor expected %h seen %h", exp, m);
                give_verdict();
            end
            cycles(1);
            n++;
        end
    endtask

    task automatic press();
        @(posedge clk) sw <= 1'b1;
        cycles(4);
        @(posedge clk) sw <= 1'b0;
        cycles(1);
    endtask

    task automatic s_first_up();
        press();
        check("first press", M_UP);
        wait_for(M_OFF, 80);
        check_n("end stop", 50, 65);
    endtask

    task automatic s_toggle();
        press();
        check("toggle down", M_DN);
        wait_for(M_OFF, 80);
        press();
        check("toggle up", M_UP);
        cycles(5);
        press();
        check("pause", M_OFF);
        wait_for(M_DN, 20);
        check_n("pause length", PAU - 3, PAU - 3);
        wait_for(M_OFF, 80);
        press();
        check("up again", M_UP);
        wait_for(M_OFF, 80);
    endtask

    task automatic s_reverse();
        @(posedge clk) begin
            speed <= 8'h14;
            rev <= 1'b1;
        end
        cycles(6);
        check("reverse lowers", M_DN);
        wait_for(M_OFF, 80);
        cycles(30);
        check("no raise at 20", M_OFF);
        @(posedge clk) speed <= 8'h15;
        cycles(6);
        check("raise above 20", M_UP);
        wait_for(M_OFF, 80);
        @(posedge clk) begin
            speed <= 8'h00;
            rev <= 1'b0;
        end
        cycles(4);
        @(posedge clk) rev <= 1'b1;
        cycles(6);
        check("reverse lowers again", M_DN);
        wait_for(M_OFF, 80);
        @(posedge clk) begin
            rev <= 1'b0;
            park <= 1'b1;
        end
        cycles(6);
        check("park raises", M_UP);
        wait_for(M_OFF, 80);
        @(posedge clk) park <= 1'b0;
    endtask

    task automatic s_manual_down();
        press();
        check("manual down", M_DN);
        wait_for(M_OFF, 80);
        @(posedge clk) begin
            rev <= 1'b1;
            speed <= 8'h15;
        end
        cycles(30);
        check("features off", M_OFF);
        @(posedge clk) begin
            rev <= 1'b0;
            speed <= 8'h00;
        end
        press();
        check("press up", M_UP);
        wait_for(M_OFF, 80);
        @(posedge clk) rev <= 1'b1;
        cycles(6);
        check("features back", M_DN);
        wait_for(M_OFF, 80);
        @(posedge clk) rev <= 1'b0;
    endtask

    task automatic s_window();
        @(posedge clk) ignition_state <= 1'b0;
        cycles(100);
        press();
        check("press in window", M_UP);
        wait_for(M_OFF, 80);
        cycles(4);
        press();
        cycles(34);
        check("travel past expiry", M_DN);
        wait_for(M_OFF, 80);
        cycles(4);
        press();
        cycles(20);
        check("press after window", M_OFF);
        @(posedge clk) ignition_state <= 1'b1;
        cycles(4);
    endtask

    task automatic s_run_limit();
        @(posedge clk) no_stop <= 1'b1;
        press();
        check("run start", M_UP);
        wait_for(M_OFF, 120);
        check_n("run limit", RUN - 3, RUN - 3);
        @(posedge clk) no_stop <= 1'b0;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        ignition_state <= 1'b1;
        cycles(2);
        s_first_up();
        s_toggle();
        s_reverse();
        s_manual_down();
        s_window();
        s_run_limit();
        give_verdict();
    end
endmodule
